// ---- rtl/brg_two_wire_timing.sv ----
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`include "brg_params.svh"
// How it works
// - multiplier code 0,1,2 gives factor 1,2,4; code 3 is reserved.
// - six-bit clock rate index selects divider and hold counts from a table.
// - one scl bit period lasts factor times divider bus clocks.
// - sda changes factor times sda-hold clocks after each scl fall.
// - start lowers sda with scl high, then holds scl high factor times start-hold.
// - stop releases sda factor times stop-hold clocks after scl rises.
// - the same factor scales all three holds; no separate control exists.
// - indices 0x00 to 0x1F return the printed table exactly.
// - indices 0x20 to 0x3F continue with the larger printed values.
module brg_two_wire_timing (
    input wire logic REF_CLK_IN,
    input wire logic RESET_IN,
    input wire logic [`BRG_ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE_OUT,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT
);
    import brg_pkg::*;

    // constant table, one row per clock rate index
    function automatic brg_lut_t lut(input logic [5:0] idx);
        case (idx)
            6'h00: lut = '{12'h014, 10'h007, 11'h006, 11'h00B};
            6'h01: lut = '{12'h016, 10'h007, 11'h007, 11'h00C};
            6'h02: lut = '{12'h018, 10'h008, 11'h008, 11'h00D};
            6'h03: lut = '{12'h01A, 10'h008, 11'h009, 11'h00E};
            6'h04: lut = '{12'h01C, 10'h009, 11'h00A, 11'h00F};
            6'h05: lut = '{12'h01E, 10'h009, 11'h00B, 11'h010};
            6'h06: lut = '{12'h022, 10'h00A, 11'h00D, 11'h012};
            6'h07: lut = '{12'h028, 10'h00A, 11'h010, 11'h015};
            6'h08: lut = '{12'h01C, 10'h007, 11'h00A, 11'h00F};
            6'h09: lut = '{12'h020, 10'h007, 11'h00C, 11'h011};
            6'h0A: lut = '{12'h024, 10'h009, 11'h00E, 11'h013};
            6'h0B: lut = '{12'h028, 10'h009, 11'h010, 11'h015};
            6'h0C: lut = '{12'h02C, 10'h00B, 11'h012, 11'h017};
            6'h0D: lut = '{12'h030, 10'h00B, 11'h014, 11'h019};
            6'h0E: lut = '{12'h038, 10'h00D, 11'h018, 11'h01D};
            6'h0F: lut = '{12'h044, 10'h00D, 11'h01E, 11'h023};
            6'h10: lut = '{12'h030, 10'h009, 11'h012, 11'h019};
            6'h11: lut = '{12'h038, 10'h009, 11'h016, 11'h01D};
            6'h12: lut = '{12'h040, 10'h00D, 11'h01A, 11'h021};
            6'h13: lut = '{12'h048, 10'h00D, 11'h01E, 11'h025};
            6'h14: lut = '{12'h050, 10'h011, 11'h022, 11'h029};
            6'h15: lut = '{12'h058, 10'h011, 11'h026, 11'h02D};
            6'h16: lut = '{12'h068, 10'h015, 11'h02E, 11'h035};
            6'h17: lut = '{12'h080, 10'h015, 11'h03A, 11'h041};
            6'h18: lut = '{12'h050, 10'h009, 11'h026, 11'h029};
            6'h19: lut = '{12'h060, 10'h009, 11'h02E, 11'h031};
            6'h1A: lut = '{12'h070, 10'h011, 11'h036, 11'h039};
            6'h1B: lut = '{12'h080, 10'h011, 11'h03E, 11'h041};
            6'h1C: lut = '{12'h090, 10'h019, 11'h046, 11'h049};
            6'h1D: lut = '{12'h0A0, 10'h019, 11'h04E, 11'h051};
            6'h1E: lut = '{12'h0C0, 10'h021, 11'h05E, 11'h061};
            6'h1F: lut = '{12'h0F0, 10'h021, 11'h076, 11'h079};
            6'h20: lut = '{12'h0A0, 10'h011, 11'h04E, 11'h051};
            6'h21: lut = '{12'h0C0, 10'h011, 11'h05E, 11'h061};
            6'h22: lut = '{12'h0E0, 10'h021, 11'h06E, 11'h071};
            6'h23: lut = '{12'h100, 10'h021, 11'h07E, 11'h081};
            6'h24: lut = '{12'h120, 10'h031, 11'h08E, 11'h091};
            6'h25: lut = '{12'h140, 10'h031, 11'h09E, 11'h0A1};
            6'h26: lut = '{12'h180, 10'h041, 11'h0BE, 11'h0C1};
            6'h27: lut = '{12'h1E0, 10'h041, 11'h0EE, 11'h0F1};
            6'h28: lut = '{12'h140, 10'h021, 11'h09E, 11'h0A1};
            6'h29: lut = '{12'h180, 10'h021, 11'h0BE, 11'h0C1};
            6'h2A: lut = '{12'h1C0, 10'h041, 11'h0DE, 11'h0E1};
            6'h2B: lut = '{12'h200, 10'h041, 11'h0FE, 11'h101};
            6'h2C: lut = '{12'h240, 10'h061, 11'h11E, 11'h121};
            6'h2D: lut = '{12'h280, 10'h061, 11'h13E, 11'h141};
            6'h2E: lut = '{12'h300, 10'h081, 11'h17E, 11'h181};
            6'h2F: lut = '{12'h3C0, 10'h081, 11'h1DE, 11'h1E1};
            6'h30: lut = '{12'h280, 10'h041, 11'h13E, 11'h141};
            6'h31: lut = '{12'h300, 10'h041, 11'h17E, 11'h181};
            6'h32: lut = '{12'h380, 10'h081, 11'h1BE, 11'h1C1};
            6'h33: lut = '{12'h400, 10'h081, 11'h1FE, 11'h201};
            6'h34: lut = '{12'h480, 10'h0C1, 11'h23E, 11'h241};
            6'h35: lut = '{12'h500, 10'h0C1, 11'h27E, 11'h281};
            6'h36: lut = '{12'h600, 10'h101, 11'h2FE, 11'h301};
            6'h37: lut = '{12'h780, 10'h101, 11'h3BE, 11'h3C1};
            6'h38: lut = '{12'h500, 10'h081, 11'h27E, 11'h281};
            6'h39: lut = '{12'h600, 10'h081, 11'h2FE, 11'h301};
            6'h3A: lut = '{12'h700, 10'h101, 11'h37E, 11'h381};
            6'h3B: lut = '{12'h800, 10'h101, 11'h3FE, 11'h401};
            6'h3C: lut = '{12'h900, 10'h181, 11'h47E, 11'h481};
            6'h3D: lut = '{12'hA00, 10'h181, 11'h4FE, 11'h501};
            6'h3E: lut = '{12'hC00, 10'h201, 11'h5FE, 11'h601};
            default: lut = '{12'hF00, 10'h201, 11'h77E, 11'h781};
        endcase
    endfunction

    // multiply by 1, 2 or 4 as a shift; code 3 shifts by 3, undefined use
    function automatic logic [`BRG_CNT_W-1:0] scale(input logic [11:0] v, input logic [1:0] m);
        scale = {4'h0, v} << m;
    endfunction

    logic ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    brg_div_t div_r, div_nxt;
    logic tx_bit_r, tx_bit_nxt;
    logic start_pend_r, start_pend_nxt, stop_pend_r, stop_pend_nxt;
    logic stop_arm_r, stop_arm_nxt;
    brg_state_t state_r, state_nxt;
    logic [`BRG_CNT_W-1:0] cnt_r, cnt_nxt;
    logic scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;
    logic start_take, stop_take, wr_en, start_wr, stop_wr;
    logic [1:0] pin_raw;
    logic pin_r [2];
    logic [2:0] sync_r [2];
    brg_lut_t tbl;
    logic [`BRG_CNT_W-1:0] period_cnt, half_cnt, sda_cnt, start_cnt, stop_cnt;

    // all timing derives from one register, so one write retimes everything
    always_comb begin
        tbl = lut(div_r.clock_rate_index);
        period_cnt = scale(tbl.div, div_r.rate_multiplier);
        half_cnt = period_cnt >> 1;
        sda_cnt = scale({2'h0, tbl.sda}, div_r.rate_multiplier);
        start_cnt = scale({1'h0, tbl.start}, div_r.rate_multiplier);
        stop_cnt = scale({1'h0, tbl.stop}, div_r.rate_multiplier);
    end

    // pin synchronisers: a level counts once stages two and three agree
    assign pin_raw = {SDA_IN, SCL_IN};
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge REF_CLK_IN) begin
            if (RESET_IN) begin
                sync_r[g] <= 3'h7;
                pin_r[g] <= 1'b1;
            end else begin
                sync_r[g] <= {sync_r[g][1:0], pin_raw[g]};
                if (sync_r[g][1] == sync_r[g][2]) begin
                    pin_r[g] <= sync_r[g][2];
                end
            end
        end
    end

    // avalon slave: one wait state, writes land on the edge waitrequest is low
    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_r;
    assign wr_en = AVS_WRITE_IN & ack_r & AVS_BYTEENABLE_IN[0];
    assign start_wr = wr_en && AVS_ADDRESS_IN == `BRG_OFS_CONTROL && AVS_WRITEDATA_IN[`BRG_CTL_START];
    assign stop_wr = wr_en && AVS_ADDRESS_IN == `BRG_OFS_CONTROL && AVS_WRITEDATA_IN[`BRG_CTL_STOP];
    always_comb begin
        ack_nxt = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_r;
        rdata_nxt = rdata_r;
        div_nxt = div_r;
        tx_bit_nxt = tx_bit_r;
        if (AVS_READ_IN && !ack_r) begin
            rdata_nxt = 32'h0000_0000; // unmapped reads as zero
            if (AVS_ADDRESS_IN == `BRG_OFS_DIVIDER) begin
                rdata_nxt[7:0] = div_r;
            end else if (AVS_ADDRESS_IN == `BRG_OFS_CONTROL) begin
                rdata_nxt[`BRG_CTL_TXBIT] = tx_bit_r;
            end else if (AVS_ADDRESS_IN == `BRG_OFS_STATUS) begin
                rdata_nxt[`BRG_STS_BUSY] = state_r != ST_IDLE;
                rdata_nxt[`BRG_STS_SCL] = pin_r[0];
                rdata_nxt[`BRG_STS_SDA] = pin_r[1];
                rdata_nxt[`BRG_STS_STOP_PEND] = stop_pend_r | stop_arm_r;
            end
        end
        if (wr_en && AVS_ADDRESS_IN == `BRG_OFS_DIVIDER) begin
            div_nxt = AVS_WRITEDATA_IN[7:0];
        end else if (wr_en && AVS_ADDRESS_IN == `BRG_OFS_CONTROL) begin
            tx_bit_nxt = AVS_WRITEDATA_IN[`BRG_CTL_TXBIT];
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            div_r <= `BRG_DIV_RESET;
            tx_bit_r <= 1'b1;
        end else begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            div_r <= div_nxt;
            tx_bit_r <= tx_bit_nxt;
        end
    end
    assign AVS_READDATA_OUT = rdata_r;

    // line sequencer; a new request wins over its own consumption
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + `BRG_CNT_ONE;
        scl_low_nxt = scl_low_r;
        sda_low_nxt = sda_low_r;
        stop_arm_nxt = stop_arm_r;
        start_take = 1'b0;
        stop_take = 1'b0;
        case (state_r)
            ST_IDLE: begin
                cnt_nxt = `BRG_CNT_ZERO;
                if (start_pend_r) begin
                    sda_low_nxt = 1'b1; // sda falls while scl high
                    start_take = 1'b1;
                    state_nxt = ST_START_HOLD;
                end
            end
            ST_START_HOLD: begin
                if (cnt_r == start_cnt - `BRG_CNT_ONE) begin
                    scl_low_nxt = 1'b1;
                    cnt_nxt = `BRG_CNT_ZERO;
                    state_nxt = ST_LOW;
                end
            end
            ST_LOW: begin
                // a stop is only armed here, so sda is low when scl rises
                if (cnt_r == sda_cnt - `BRG_CNT_ONE) begin
                    sda_low_nxt = stop_pend_r | ~tx_bit_r;
                    stop_arm_nxt = stop_pend_r;
                    stop_take = stop_pend_r;
                end
                if (cnt_r == half_cnt - `BRG_CNT_ONE) begin
                    scl_low_nxt = 1'b0;
                    cnt_nxt = `BRG_CNT_ZERO;
                    state_nxt = stop_arm_nxt ? ST_STOP_HOLD : ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (cnt_r == period_cnt - half_cnt - `BRG_CNT_ONE) begin
                    scl_low_nxt = 1'b1;
                    cnt_nxt = `BRG_CNT_ZERO;
                    state_nxt = ST_LOW;
                end
            end
            ST_STOP_HOLD: begin
                if (cnt_r == stop_cnt - `BRG_CNT_ONE) begin
                    sda_low_nxt = 1'b0;
                    stop_arm_nxt = 1'b0;
                    cnt_nxt = `BRG_CNT_ZERO;
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        start_pend_nxt = start_wr | (start_pend_r & ~start_take);
        stop_pend_nxt = stop_wr | (stop_pend_r & ~stop_take);
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            state_r <= ST_IDLE;
            cnt_r <= `BRG_CNT_ZERO;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            stop_arm_r <= 1'b0;
            start_pend_r <= 1'b0;
            stop_pend_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            scl_low_r <= scl_low_nxt;
            sda_low_r <= sda_low_nxt;
            stop_arm_r <= stop_arm_nxt;
            start_pend_r <= start_pend_nxt;
            stop_pend_r <= stop_pend_nxt;
        end
    end

    // open-drain pins only ever pull low
    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE_OUT = scl_low_r;
    assign SDA_OE_OUT = sda_low_r;

    // helper: bus clocks since the last scl fall
    logic [`BRG_CNT_W-1:0] since_fall_r;
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN || (scl_low_nxt && !scl_low_r)) since_fall_r <= `BRG_CNT_ZERO;
        else since_fall_r <= since_fall_r + `BRG_CNT_ONE;
    end

    property p_rate_multiplier_decode;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        div_r.rate_multiplier != 2'h3 |-> period_cnt ==
            (div_r.rate_multiplier == 2'h0 ? {4'h0, tbl.div} :
             div_r.rate_multiplier == 2'h1 ? {3'h0, tbl.div, 1'b0} : {2'h0, tbl.div, 2'h0});
    endproperty
    a_rate_multiplier_decode: assert property (p_rate_multiplier_decode) else $error("multiplier decode wrong");
    property p_lut_low;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        div_r.clock_rate_index == 6'h1F |-> tbl.div == 12'h0F0 && tbl.start == 11'h076 && tbl.stop == 11'h079;
    endproperty
    a_lut_low: assert property (p_lut_low) else $error("table row 1F wrong");
    property p_lut_high;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        div_r.clock_rate_index == 6'h20 |-> tbl.div == 12'h0A0 && tbl.sda == 10'h011 && tbl.stop == 11'h051;
    endproperty
    a_lut_high: assert property (p_lut_high) else $error("table row 20 wrong");
    property p_bit_period;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        $rose(scl_low_r) && $past(state_r) == ST_HIGH && $stable(div_r)
            |-> $past(since_fall_r) == period_cnt - `BRG_CNT_ONE;
    endproperty
    a_bit_period: assert property (p_bit_period) else $error("bit period wrong");
    property p_sda_hold;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        $changed(sda_low_r) && $past(state_r) == ST_LOW |-> $past(since_fall_r) == sda_cnt - `BRG_CNT_ONE;
    endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("sda hold wrong");
    property p_start_hold;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        $rose(scl_low_r) && $past(state_r) == ST_START_HOLD
            |-> $past(cnt_r) == start_cnt - `BRG_CNT_ONE && sda_low_r;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start hold wrong");
    property p_stop_hold;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        $fell(sda_low_r) && $past(state_r) == ST_STOP_HOLD
            |-> $past(cnt_r) == stop_cnt - `BRG_CNT_ONE && !scl_low_r && state_r == ST_IDLE;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop hold wrong");
    property p_hold_scaled;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        div_r.rate_multiplier == 2'h2 |-> sda_cnt == {4'h0, tbl.sda, 2'h0} && stop_cnt == {3'h0, tbl.stop, 2'h0};
    endproperty
    a_hold_scaled: assert property (p_hold_scaled) else $error("hold not scaled");
    property p_one_wait;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("waitrequest held too long");
    c_start: cover property (@(posedge REF_CLK_IN) disable iff (RESET_IN) state_r == ST_START_HOLD ##1 state_r == ST_LOW);
    c_bit: cover property (@(posedge REF_CLK_IN) disable iff (RESET_IN) state_r == ST_HIGH ##1 state_r == ST_LOW);
    c_stop: cover property (@(posedge REF_CLK_IN) disable iff (RESET_IN) state_r == ST_STOP_HOLD ##1 state_r == ST_IDLE);
endmodule // brg_two_wire_timing

// ---- rtl/brg_params.svh ----
`ifndef BRG_PARAMS_SVH
`define BRG_PARAMS_SVH
// register map, byte addresses
`define BRG_ADDR_W 4
`define BRG_OFS_DIVIDER 4'h0
`define BRG_OFS_CONTROL 4'h4
`define BRG_OFS_STATUS 4'h8
`define BRG_DIV_RESET 8'h00
// divider register fields
`define BRG_RATE_MULTIPLIER_HI 7
`define BRG_RATE_MULTIPLIER_LO 6
`define BRG_ICR_HI 5
`define BRG_ICR_LO 0
// control register fields
`define BRG_CTL_START 0
`define BRG_CTL_STOP 1
`define BRG_CTL_TXBIT 2
// status register fields
`define BRG_STS_BUSY 0
`define BRG_STS_SCL 1
`define BRG_STS_SDA 2
`define BRG_STS_STOP_PEND 3
// bus clock counters
`define BRG_CNT_W 16
`define BRG_CNT_ONE 16'h0001
`define BRG_CNT_ZERO 16'h0000
`endif

// ---- rtl/brg_pkg.sv ----
package brg_pkg;
    // one lookup row: scl divider and the three hold counts
    typedef struct packed {
        logic [11:0] div;
        logic [9:0] sda;
        logic [10:0] start;
        logic [10:0] stop;
    } brg_lut_t;

    // divider register as software sees it
    typedef struct packed {
        logic [1:0] rate_multiplier;
        logic [5:0] clock_rate_index;
    } brg_div_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START_HOLD,
        ST_LOW,
        ST_HIGH,
        ST_STOP_HOLD
    } brg_state_t;
endpackage

// ---- test/brg_bus_partner.sv ----
`timescale 1ns/100ps
// the other stations on the shared lines stay released, so only the pull-ups and the device act
// limitation: never stretches the clock, because the engine does not watch the lines
module brg_bus_partner (
    input wire logic scl_drv_in,
    input wire logic scl_oe_in,
    input wire logic sda_drv_in,
    input wire logic sda_oe_in,
    output logic scl_line_out,
    output logic sda_line_out
);
    // wired-and with pull-ups: a released line reads high
    always_comb begin
        scl_line_out = scl_oe_in ? scl_drv_in : 1'b1;
        sda_line_out = sda_oe_in ? sda_drv_in : 1'b1;
    end
endmodule // brg_bus_partner

// ---- test/brg_testbench.sv ----
`timescale 1ns/100ps
`include "brg_params.svh"
module testbench;
    import brg_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [`BRG_ADDR_W-1:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic scl_line;
    logic scl_drv;
    logic scl_oe;
    logic sda_line;
    logic sda_drv;
    logic sda_oe;
    int fail_count = 0;
    int num_checks = 0;

    // 250 MHz reference
    always #2 ref_clk = ~ref_clk;

    brg_two_wire_timing u_dut (
        .REF_CLK_IN(ref_clk),
        .RESET_IN(reset),
        .AVS_ADDRESS_IN(avs_address),
        .AVS_READ_IN(avs_read),
        .AVS_WRITE_IN(avs_write),
        .AVS_BYTEENABLE_IN(avs_byteenable),
        .AVS_WRITEDATA_IN(avs_writedata),
        .AVS_READDATA_OUT(avs_readdata),
        .AVS_WAITREQUEST_OUT(avs_waitrequest),
        .SCL_IN(scl_line),
        .SCL_OUT(scl_drv),
        .SCL_OE_OUT(scl_oe),
        .SDA_IN(sda_line),
        .SDA_OUT(sda_drv),
        .SDA_OE_OUT(sda_oe)
    );

    brg_bus_partner u_partner (
        .scl_drv_in(scl_drv),
        .scl_oe_in(scl_oe),
        .sda_drv_in(sda_drv),
        .sda_oe_in(sda_oe),
        .scl_line_out(scl_line),
        .sda_line_out(sda_line)
    );

    // verdict, reached from the main sequence or from a hang
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // one avalon transfer; request held until the rising edge that sees waitrequest low
    task automatic bus_op(input logic wr, input logic [3:0] addr, input logic [31:0] data, output logic [31:0] rd);
        @(posedge ref_clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= wr;
        avs_read <= ~wr;
        // values read here are those sampled at the edge, before the slave updates
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // counts falling edges until the chosen enable (0 scl, 1 sda) shows val; bounded
    task automatic wait_val(input int sel, input logic val, output int n);
        n = 0;
        while (((sel == 0) ? scl_oe : sda_oe) !== val && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 20000) begin
            fail_count++;
            $display("Error at %0t: wait on line %0h never saw %0h", $time, sel, val);
            summarize();
        end
    endtask

    // reset values, read back, reserved address and read-only status
    task automatic reg_checks();
        logic [31:0] rd;
        bus_op(1'b0, `BRG_OFS_DIVIDER, 32'h0, rd);
        check_val(rd, 32'h00000000);
        bus_op(1'b0, `BRG_OFS_CONTROL, 32'h0, rd);
        check_val(rd, 32'h00000004);
        bus_op(1'b0, `BRG_OFS_STATUS, 32'h0, rd);
        check_val(rd, 32'h00000006);
        bus_op(1'b1, `BRG_OFS_DIVIDER, 32'hFFFF1285, rd);
        bus_op(1'b1, 4'hC, 32'h000000FF, rd);
        bus_op(1'b1, `BRG_OFS_STATUS, 32'h000000FF, rd);
        bus_op(1'b0, `BRG_OFS_DIVIDER, 32'h0, rd);
        check_val(rd, 32'h00000085);
        // lane 0 disabled: the write must be ignored
        avs_byteenable <= 4'hE;
        bus_op(1'b1, `BRG_OFS_DIVIDER, 32'h00000000, rd);
        avs_byteenable <= 4'hF;
        bus_op(1'b0, `BRG_OFS_DIVIDER, 32'h0, rd);
        check_val(rd, 32'h00000085);
        // open-drain data outputs only ever pull low
        check_val({30'h0, scl_drv, sda_drv}, 32'h00000000);
        bus_op(1'b0, 4'hC, 32'h0, rd);
        check_val(rd, 32'h00000000);
        bus_op(1'b0, `BRG_OFS_STATUS, 32'h0, rd);
        check_val(rd, 32'h00000006);
    endtask

    // one start, one full bit and one stop at a given setting, timing start hold, sda hold, half and full bit period and stop hold
    task automatic run_cfg(input logic [1:0] code, input logic [5:0] idx, input int dv, input int sh,
                           input int st, input int sp);
        brg_div_t cfg;
        int m;
        int n1;
        int n2;
        int n3;
        logic [31:0] rd;
        cfg.rate_multiplier = code;
        cfg.clock_rate_index = idx;
        m = 1 << code;
        bus_op(1'b1, `BRG_OFS_DIVIDER, {24'h000000, cfg}, rd);
        bus_op(1'b1, `BRG_OFS_CONTROL, 32'h00000005, rd);
        @(negedge ref_clk);
        wait_val(1, 1'b1, n1);
        check_val({31'h0, scl_line}, 32'h00000001);
        wait_val(0, 1'b1, n1);
        check_val(n1, m * st);
        wait_val(1, 1'b0, n1);
        wait_val(0, 1'b0, n2);
        wait_val(0, 1'b1, n3);
        check_val(n1, m * sh);
        check_val(n1 + n2, (m * dv) / 2);
        check_val(n1 + n2 + n3, m * dv);
        // stop must land before this low phase reaches its data change point
        bus_op(1'b1, `BRG_OFS_CONTROL, 32'h00000006, rd);
        @(negedge ref_clk);
        wait_val(0, 1'b0, n1);
        wait_val(1, 1'b0, n2);
        check_val(n2, m * sp);
        bus_op(1'b0, `BRG_OFS_STATUS, 32'h0, rd);
        check_val(rd & 32'h00000001, 32'h00000000);
    endtask

    // hang guard: the longest setting needs about ten thousand cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        $display("Error at %0t: watchdog %0h expected %0h", $time, 1, 0);
        summarize();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        reg_checks();
        run_cfg(2'h0, 6'h00, 20, 7, 6, 11);
        run_cfg(2'h1, 6'h1F, 240, 33, 118, 121);
        run_cfg(2'h2, 6'h20, 160, 17, 78, 81);
        run_cfg(2'h0, 6'h3F, 3840, 513, 1918, 1921);
        run_cfg(2'h2, 6'h07, 40, 10, 16, 21);
        summarize();
    end
endmodule // testbench
